/* shared/qbio_pkg.sv */
package qbio_pkg;
    // ********************************
    // clock and tone timing
    // ********************************
    localparam int CLK_HZ       = 250_000_000;
    localparam int TONE_BASE_HZ = 2000;
    localparam int TONE_HALF    = CLK_HZ / (2 * TONE_BASE_HZ);
    localparam int TONE_CNT_W   = 17;
    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [7:0] OFS_P0_DATA = 8'h00;
    localparam logic [7:0] OFS_P0_SET  = 8'h04;
    localparam logic [7:0] OFS_P0_CLR  = 8'h08;
    localparam logic [7:0] OFS_P1_DATA = 8'h10;
    localparam logic [7:0] OFS_P1_SET  = 8'h14;
    localparam logic [7:0] OFS_P1_CLR  = 8'h18;
    localparam logic [7:0] OFS_DIR     = 8'h20;
    localparam logic [7:0] OFS_ODRAIN  = 8'h24;
    localparam logic [7:0] OFS_PULL    = 8'h28;
    localparam logic [7:0] OFS_EDGE    = 8'h2C;
    localparam logic [7:0] OFS_ALT     = 8'h30;
    localparam logic [7:0] OFS_STAT    = 8'h34;
    localparam logic [7:0] OFS_MASK    = 8'h38;
    // ********************************
    // field positions
    // ********************************
    localparam int ALT_TMR   = 0;
    localparam int ALT_TONE  = 1;
    localparam int ALT_CLK   = 2;
    localparam int ALT_FSEL  = 4;
    localparam int ST_EXTA   = 4;
    localparam int ST_EXTB   = 5;
    localparam int ST_QUASI  = 6;
    localparam int ST_EXTC   = 7;
    localparam logic [7:0] IRQ_VEC_MASK = 8'hBF;
    // ********************************
    // reset values
    // ********************************
    localparam logic [3:0] RST_LATCH = 4'h0;
    localparam logic [7:0] RST_DIR   = 8'h00;
    localparam logic [7:0] RST_ODR   = 8'h00;
    localparam logic [7:0] RST_PULL  = 8'h00;
    localparam logic [7:0] RST_EDGE  = 8'h00;
    localparam logic [5:0] RST_ALT   = 6'h00;
    localparam logic [7:0] RST_MASK  = 8'h00;
endpackage

/* hdl/qbio_edge_det.sv */
`timescale 1ns/1ns
module qbio_edge_det (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pinIn,
    input  wire logic riseSel,
    output logic      level,
    output logic      edgeHit
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } qbio_edge_s;

    qbio_edge_s st, nxt;

    // two flops, then a history flop for the edge compare
    always_comb begin
        nxt      = st;
        nxt.meta = pinIn;
        nxt.sync = st.meta;
        nxt.prev = st.sync;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign level   = st.prev;
    // only the second and third stages feed the compare
    assign edgeHit = riseSel ? (st.sync & ~st.prev) : (~st.sync & st.prev);
endmodule

/* hdl/qbio_top.sv */
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
module qbio_top #(
    parameter int TONE_HALF_BASE = qbio_pkg::TONE_HALF
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        timer0Clk,
    input  wire logic        sysClk,
    input  wire logic [3:0]  firstQuadIn,
    output logic [3:0]       firstQuadOut,
    output logic [3:0]       firstQuadOe,
    output logic [3:0]       firstQuadPullEn,
    input  wire logic [3:0]  secondQuadIn,
    output logic [3:0]       secondQuadOut,
    output logic [3:0]       secondQuadOe,
    output logic [3:0]       secondQuadPullEn,
    output logic             irq
);
    import qbio_pkg::*;

    typedef struct packed {
        logic [3:0]            latch0;
        logic [3:0]            latch1;
        logic [7:0]            dir;
        logic [7:0]            odr;
        logic [7:0]            pull;
        logic [7:0]            edgeSel;
        logic [5:0]            alt;
        logic [7:0]            stat;
        logic [7:0]            mask;
        logic                  wrPend;
        logic [7:0]            wrAddr;
        logic [31:0]           rdata;
        logic [TONE_CNT_W-1:0] toneCnt;
        logic                  toneLvl;
        logic [7:0]            padOut;
        logic [7:0]            padOe;
        logic [7:0]            padPull;
        logic                  irq;
    } qbio_state_s;

    qbio_state_s st, nxt;

    logic [7:0]            pinLvl;
    logic [7:0]            evt;
    logic [7:0]            altMask;
    logic [7:0]            altVal;
    logic [7:0]            drv;
    logic [7:0]            val;
    logic                  take;
    logic [7:0]            aOfs;
    logic [TONE_CNT_W-1:0] toneHalf;
    logic                  toneOn;

    // ********************************
    // input synchronisers and edge detectors
    // ********************************
    // port 0 bits are key inputs; port 1 bits are ext a, ext b, quasi, ext c
    // edge bit 1 selects rising, 0 falling, one bit per pin
    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_pin
        qbio_edge_det u_det (
            .clk     (clk),
            .rst_b   (rst_b),
            .pinIn   ((gi < 4) ? firstQuadIn[gi % 4] : secondQuadIn[gi % 4]),
            .riseSel (st.edgeSel[gi]),
            .level   (pinLvl[gi]),
            .edgeHit (evt[gi])
        );
    end

    // ********************************
    // alternate output functions
    // ********************************
    // tone wins over the system clock on pin 2; both cannot share it
    assign toneOn = st.alt[ALT_TONE];
    always_comb begin
        altMask = 8'h00;
        altVal  = 8'h00;
        if (st.alt[ALT_TMR]) begin
            altMask[1:0] = 2'h3;
            altVal[0]    = timer0Clk;
            altVal[1]    = ~timer0Clk;
        end
        if (toneOn) begin
            altMask[3:2] = 2'h3;
            altVal[3]    = st.toneLvl;
            altVal[2]    = ~st.toneLvl;
        end else if (st.alt[ALT_CLK]) begin
            altMask[2] = 1'b1;
            altVal[2]  = sysClk;
        end
    end

    // half period shrinks by powers of two: 2, 4, 8 or 16 kHz
    assign toneHalf = TONE_CNT_W'(TONE_HALF_BASE) >> st.alt[ALT_FSEL +: 2];

    // ********************************
    // bus decode
    // ********************************
    // only the low byte of the address is decoded; the rest aliases
    assign take = hsel & htrans[1] & hready;
    assign aOfs = {haddr[7:2], 2'b00};

    function automatic logic [31:0] rd_mux(input qbio_state_s s, input logic [7:0] a,
                                           input logic [7:0] lv);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            OFS_P0_DATA: r[7:0] = {s.latch0, lv[3:0]};
            OFS_P1_DATA: r[7:0] = {s.latch1, lv[7:4]};
            OFS_DIR:     r[7:0] = s.dir;
            OFS_ODRAIN:  r[7:0] = s.odr;
            OFS_PULL:    r[7:0] = s.pull;
            OFS_EDGE:    r[7:0] = s.edgeSel;
            OFS_ALT:     r[5:0] = s.alt;
            OFS_STAT:    r[7:0] = s.stat;
            OFS_MASK:    r[7:0] = s.mask;
            default:     r      = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ********************************
    // next state
    // ********************************
    always_comb begin
        nxt = st;
        // address phase: remember writes, fetch read data now
        nxt.wrPend = take & hwrite;
        if (take) begin
            nxt.wrAddr = aOfs;
        end
        if (take && !hwrite) begin
            nxt.rdata = rd_mux(st, aOfs, pinLvl);
        end
        // data phase writes; whole-port or single-pin through set and clear
        if (st.wrPend) begin
            unique case (st.wrAddr)
                OFS_P0_DATA: nxt.latch0 = hwdata[3:0];
                OFS_P0_SET:  nxt.latch0 = st.latch0 | hwdata[3:0];
                OFS_P0_CLR:  nxt.latch0 = st.latch0 & ~hwdata[3:0];
                OFS_P1_DATA: nxt.latch1 = hwdata[3:0];
                OFS_P1_SET:  nxt.latch1 = st.latch1 | hwdata[3:0];
                OFS_P1_CLR:  nxt.latch1 = st.latch1 & ~hwdata[3:0];
                OFS_DIR:     nxt.dir = hwdata[7:0];
                OFS_ODRAIN:  nxt.odr = hwdata[7:0];
                OFS_PULL:    nxt.pull = hwdata[7:0];
                OFS_EDGE:    nxt.edgeSel = hwdata[7:0];
                OFS_ALT:     nxt.alt = hwdata[5:0];
                OFS_MASK:    nxt.mask = hwdata[7:0];
                default:     nxt.mask = st.mask;
            endcase
        end
        // read of status clears it, an edge in the same cycle survives
        nxt.stat = st.stat;
        if (take && !hwrite && aOfs == OFS_STAT) begin
            nxt.stat = 8'h00;
        end
        nxt.stat = nxt.stat | evt;
        // tone divider, held at rest while the function is off
        if (!toneOn) begin
            nxt.toneCnt = '0;
            nxt.toneLvl = 1'b0;
        end else if (st.toneCnt == '0) begin
            nxt.toneCnt = toneHalf - TONE_CNT_W'(1);
            nxt.toneLvl = ~st.toneLvl;
        end else begin
            nxt.toneCnt = st.toneCnt - TONE_CNT_W'(1);
        end
        // pad drive: alternate functions force the pin to output, open-drain still applies, and replace the latch
        drv = st.dir | altMask;
        val = (altMask & altVal) | (~altMask & {st.latch1, st.latch0});
        nxt.padOut  = val;
        nxt.padOe   = drv & (~st.odr | ~val);
        nxt.padPull = st.pull & ~drv;
        // quasi flag is kept out of the interrupt line
        nxt.irq = |(nxt.stat & nxt.mask & IRQ_VEC_MASK);
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st         <= '0;
            st.latch0  <= RST_LATCH;
            st.latch1  <= RST_LATCH;
            st.dir     <= RST_DIR;
            st.odr     <= RST_ODR;
            st.pull    <= RST_PULL;
            st.edgeSel <= RST_EDGE;
            st.alt     <= RST_ALT;
            st.mask    <= RST_MASK;
        end else begin
            st <= nxt;
        end
    end

    // ********************************
    // outputs
    // ********************************
    // zero wait states: the read mux is taken in the address phase
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign hrdata           = st.rdata;
    assign firstQuadOut     = st.padOut[3:0];
    assign firstQuadOe      = st.padOe[3:0];
    assign firstQuadPullEn  = st.padPull[3:0];
    assign secondQuadOut    = st.padOut[7:4];
    assign secondQuadOe     = st.padOe[7:4];
    assign secondQuadPullEn = st.padPull[7:4];
    assign irq              = st.irq;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic       pastAltTmr;
    logic       pastTone;
    logic       pastClkAlt;
    logic [7:0] pastLvl;
    logic [7:0] pastEdge;
    logic [7:0] keyHit;

    // registered history, because a sampled-value call cannot feed a net
    always_ff @(posedge clk) begin
        pastAltTmr <= st.alt[ALT_TMR];
        pastTone   <= toneOn;
        pastClkAlt <= st.alt[ALT_CLK] & ~toneOn;
        pastLvl    <= pinLvl;
        pastEdge   <= st.edgeSel;
    end

    // a level step of the selected polarity, seen at the history flop
    assign keyHit = (pinLvl ^ pastLvl) & ~(pastEdge ^ pinLvl);

    chk_bit_set: assert property (
        (st.wrPend && st.wrAddr == OFS_P0_SET) |=> st.latch0 == ($past(st.latch0) | $past(hwdata[3:0])))
        else $error("port 0 set write did not set the latch bits");
    chk_dir_input: assert property (
        1'b1 |=> (st.padOe & ~$past(st.dir | altMask)) == 8'h00)
        else $error("input pin is driven");
    chk_odrain_high: assert property (
        1'b1 |=> (st.padOe & st.padOut & $past(st.odr)) == 8'h00)
        else $error("open-drain pin drives high");
    chk_pull_follow: assert property (
        ##1 (st.pull == $past(st.pull) && st.dir == $past(st.dir) && altMask == $past(altMask))
        |=> st.padPull == ($past(st.pull) & ~$past(st.dir | altMask)))
        else $error("pull-up enable not applied");
    chk_pull_off_out: assert property (
        1'b1 |=> (st.padPull & $past(st.dir)) == 8'h00)
        else $error("pull-up left on at an output pin");
    chk_quasi_no_irq: assert property (
        (st.stat == (8'h01 << ST_QUASI)) |-> !irq)
        else $error("quasi flag alone raised the interrupt");
    chk_edge_flag: assert property (
        (evt != 8'h00) |=> (st.stat & $past(evt)) == $past(evt))
        else $error("detected edge did not set its flag");
    chk_tone_comp: assert property (
        (pastTone && toneOn) |-> st.padOut[2] == ~st.padOut[3])
        else $error("tone complement wrong");
    chk_tone_toggle: assert property (
        (toneOn && st.toneCnt == '0) |=> st.toneLvl != $past(st.toneLvl))
        else $error("tone did not toggle at end of half period");
    chk_timer_copy: assert property (
        pastAltTmr |-> (st.padOut[0] == $past(timer0Clk) && st.padOut[1] == ~$past(timer0Clk)))
        else $error("timer clock not on port 0 pins 0 and 1");
    chk_irq_level: assert property (
        irq == |(st.stat & st.mask & IRQ_VEC_MASK))
        else $error("interrupt output disagrees with status and mask");

    property p_reset_cfg;
        @(posedge clk) disable iff (1'b0)
        !rst_b |=> (st.dir == RST_DIR && st.padOe == 8'h00 && !irq);
    endproperty
    chk_reset_cfg: assert property (p_reset_cfg)
        else $error("configuration not at defaults after reset");

    cov_key_irq:    cover property (evt[0] ##1 irq);
    cov_tone_run:   cover property (toneOn && st.toneCnt == '0);
    cov_stat_clear: cover property (take && !hwrite && aOfs == OFS_STAT && st.stat != 8'h00);
    cov_od_low:     cover property (|(st.padOe & ~st.padOut & st.odr));
    cov_quasi_seen: cover property (keyHit[ST_QUASI] && st.mask[ST_QUASI]);

    // ********************************
    // per pin edge flags and pin muxing
    // ********************************
    // flags are checked against the synchronised level, never the raw pad
    chk_key_edges: assert property (
        (st.stat[3:0] & keyHit[3:0]) == keyHit[3:0])
        else $error("key edge did not set its flag");
    chk_ext_pair: assert property (
        (st.stat[ST_EXTB:ST_EXTA] & keyHit[ST_EXTB:ST_EXTA]) == keyHit[ST_EXTB:ST_EXTA])
        else $error("external edge did not set its flag");
    chk_quasi_flag: assert property (
        keyHit[ST_QUASI] |-> st.stat[ST_QUASI])
        else $error("quasi edge did not set its flag");
    chk_extc_flag: assert property (
        keyHit[ST_EXTC] |-> st.stat[ST_EXTC])
        else $error("third external edge did not set its flag");
    chk_stat_clear: assert property (
        (take && !hwrite && aOfs == OFS_STAT && evt == 8'h00) |=> st.stat == 8'h00)
        else $error("status read did not clear the flags");
    chk_tone_pin: assert property (
        pastTone |-> st.padOut[3] == $past(st.toneLvl))
        else $error("tone pin not driven from the tone divider");
    chk_sysclk_pin: assert property (
        pastClkAlt |-> st.padOut[2] == $past(sysClk))
        else $error("clock pin not driven from the system clock");
    chk_tone_rest: assert property (
        !toneOn |=> !st.toneLvl)
        else $error("tone level not at rest while off");
    chk_whole_write: assert property (
        (st.wrPend && st.wrAddr == OFS_P1_DATA) |=> st.latch1 == $past(hwdata[3:0]))
        else $error("port 1 whole write did not land");
    chk_push_pull: assert property (
        1'b1 |=> (~st.padOe & $past(st.dir) & ~$past(st.odr)) == 8'h00)
        else $error("push-pull output pin not driven");
endmodule

/* test/qbio_board.sv */
`timescale 1ns/1ns
// ****************
// board side of the pads
// ****************
module qbio_board (
    input  wire logic       clk,
    input  wire logic [7:0] padOut,
    input  wire logic [7:0] padOe,
    input  wire logic [7:0] padPull,
    input  wire logic [7:0] keyEn,
    input  wire logic [7:0] keyVal,
    output logic      [7:0] padLvl
);
    logic [7:0] floatPat;

    // a floating pad wanders, so nobody may trust its last level
    initial floatPat = 8'h5A;
    always @(posedge clk) begin
        floatPat <= ~floatPat;
    end

    // chip drive wins, then a pressed key, then the pull-up, else noise
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            padLvl[i] = padOe[i] ? padOut[i] : keyEn[i] ? keyVal[i] :
                        padPull[i] ? 1'b1 : floatPat[i];
        end
    end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ns
// ****************
// port block bench
// ****************
module testbench;
    import qbio_pkg::*;
    localparam int HALF = 16;
    logic        clk, rst_b, hwrite, hreadyout, hresp, irq, timer0Clk, sysClk;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, seed, rd;
    logic [3:0]  o0, e0, p0, o1, e1, p1;
    logic [7:0]  keyEn, keyVal, lvl, d, o, p, v, a, b, e, m, s;
    int          errorCnt, nChecks, n;

    qbio_top #(.TONE_HALF_BASE(HALF)) DUT (
        .clk(clk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer0Clk(timer0Clk), .sysClk(sysClk),
        .firstQuadIn(lvl[3:0]), .firstQuadOut(o0), .firstQuadOe(e0),
        .firstQuadPullEn(p0), .secondQuadIn(lvl[7:4]), .secondQuadOut(o1),
        .secondQuadOe(e1), .secondQuadPullEn(p1), .irq(irq));

    qbio_board board (
        .clk(clk), .padOut({o1, o0}), .padOe({e1, e0}), .padPull({p1, p0}),
        .keyEn(keyEn), .keyVal(keyVal), .padLvl(lvl));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************
    // helpers
    // ****************
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic conclude();
        $display("checks %0d, errors %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        nChecks++;
        if (got !== ex) begin
            errorCnt++;
            $display("wrong value %s: expected %h, seen %h", nm, ex, got);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic waitRdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            errorCnt++;
            conclude();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
        haddr <= {24'h0, ad};
        htrans <= 2'b10;
        hwrite <= wr;
        waitRdy();
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
    endtask

    task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] ex);
        bus(ad, 1'b0, 32'h0);
        chk(nm, ex, rd);
    endtask

    // counts cycles between two tone flips, after two flips so the new rate is loaded
    task automatic toneHalf();
        logic t;
        for (int r = 0; r < 3; r++) begin
            @(posedge clk);
            t = o0[3];
            n = 1;
            while (o0[3] === t && n < 300) begin
                @(posedge clk);
                n++;
            end
        end
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        seed = 32'd19584;
        errorCnt = 0;
        nChecks = 0;
        rst_b = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        timer0Clk = 1'b0;
        sysClk = 1'b0;
        keyEn = 8'hFF;
        keyVal = 8'h00;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // direction, drive type, pull-up and latch per pin
        for (int k = 0; k < 6; k++) begin
            d = rnd();
            o = rnd();
            p = rnd();
            v = rnd();
            if (k == 0) begin
                d = 8'hFF;
                o = 8'hF0;
            end
            bus(OFS_DIR, 1'b1, 32'(d));
            bus(OFS_ODRAIN, 1'b1, 32'(o));
            bus(OFS_PULL, 1'b1, 32'(p));
            bus(OFS_P0_DATA, 1'b1, 32'(v[3:0]));
            bus(OFS_P1_DATA, 1'b1, 32'(v[7:4]));
            keyVal <= rnd();
            repeat (5) @(posedge clk);
            s = d & (~o | ~v);
            chk("oe", 32'(s), 32'({e1, e0}));
            chk("out", 32'(v), 32'({o1, o0}));
            chk("pullEn", 32'(p & ~d), 32'({p1, p0}));
            rdc("odrain", OFS_ODRAIN, 32'(o));
            rdc("p0data", OFS_P0_DATA, 32'({v[3:0], (s[3:0] & v[3:0]) | (~s[3:0] & keyVal[3:0])}));
        end
        bus(OFS_P1_SET, 1'b1, 32'h1);
        bus(OFS_P1_CLR, 1'b1, 32'h8);
        bus(OFS_P0_SET, 1'b1, 32'h2);
        bus(OFS_P0_CLR, 1'b1, 32'h1);
        repeat (3) @(posedge clk);
        chk("setClr", 32'((v[7:4] | 4'h1) & 4'h7), 32'(o1));
        chk("setClr0", 32'((v[3:0] | 4'h2) & 4'hE), 32'(o0));
        rdc("unmapped", 8'h3C, 32'h0);
        // pull-up holds an undriven input high
        bus(OFS_DIR, 1'b1, 32'h0);
        bus(OFS_PULL, 1'b1, 32'hF0);
        keyEn <= 8'h0F;
        repeat (6) @(posedge clk);
        rdc("pullLvl", OFS_P1_DATA, 32'({(v[7:4] | 4'h1) & 4'h7, 4'hF}));
        keyEn <= 8'hFF;
        // edge flags and interrupt, with fixed corners first
        for (int k = 0; k < 10; k++) begin
            a = rnd();
            b = rnd();
            e = rnd();
            m = rnd();
            if (k == 0) begin
                a = 8'h00;
                b = 8'hFF;
                e = 8'hFF;
                m = 8'h40;
            end
            if (k == 1) begin
                a = 8'hFF;
                b = 8'h00;
                e = 8'h00;
                m = 8'hFF;
            end
            bus(OFS_EDGE, 1'b1, 32'(e));
            bus(OFS_MASK, 1'b1, 32'(m));
            keyVal <= a;
            repeat (8) @(posedge clk);
            bus(OFS_STAT, 1'b0, 32'h0);
            keyVal <= b;
            repeat (8) @(posedge clk);
            s = (a ^ b) & ~(b ^ e);
            chk("irq", 32'(|(s & m & IRQ_VEC_MASK)), 32'(irq));
            rdc("stat", OFS_STAT, 32'(s));
            chk("irqClr", 32'h0, 32'(irq));
            rdc("statClr", OFS_STAT, 32'h0);
        end
        // alternate outputs override the latch
        bus(OFS_P0_DATA, 1'b1, 32'h0);
        bus(OFS_ODRAIN, 1'b1, 32'h0);
        timer0Clk <= 1'b1;
        bus(OFS_ALT, 1'b1, 32'h3);
        repeat (3) @(posedge clk);
        chk("tmrOut", 32'h1, 32'(o0[1:0]));
        chk("altOe", 32'hF, 32'(e0));
        timer0Clk <= 1'b0;
        repeat (3) @(posedge clk);
        chk("tmrOut", 32'h2, 32'(o0[1:0]));
        for (int f = 0; f < 4; f++) begin
            bus(OFS_ALT, 1'b1, 32'((f << 4) | 3));
            toneHalf();
            chk("toneHalf", 32'(HALF >> f), 32'(n));
            chk("toneInv", {31'h0, ~o0[3]}, {31'h0, o0[2]});
        end
        bus(OFS_ALT, 1'b1, 32'h4);
        sysClk <= 1'b1;
        repeat (3) @(posedge clk);
        chk("clkOut", 32'h1, 32'(o0[2]));
        // reset in mid-run drops every setting
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        chk("rstPads", 32'h0, 32'({e1, e0, p1, p0, o1, o0, 7'h0, irq}));
        rst_b <= 1'b1;
        @(posedge clk);
        rdc("rstAlt", OFS_ALT, 32'h0);
        rdc("rstDir", OFS_DIR, 32'h0);
        conclude();
    end
endmodule
